// ==== fire_unit_pkg.sv ====
package fire_unit_pkg;

	// Unit counts and address width
	localparam int NUM_TRIG      = 4;
	localparam int NUM_STAMP     = 2;
	localparam int ADDR_W        = 12;

	// Register offsets
	localparam logic [11:0] OFS_UNIT_INDEX   = 12'h520;
	localparam logic [11:0] OFS_STAMP_CTRL   = 12'h52C;
	localparam logic [11:0] OFS_TARGET_NS    = 12'h530;
	localparam logic [11:0] OFS_TARGET_SEC   = 12'h534;
	localparam logic [11:0] OFS_TRIG_CTRL1   = 12'h538;
	localparam logic [11:0] OFS_IRQ_STATUS   = 12'h540;
	localparam logic [11:0] OFS_IRQ_MASK     = 12'h544;

	// Unit index register fields
	localparam int IDX_TRIG_LSB  = 0;
	localparam int IDX_STAMP_BIT = 8;

	// Stamp control and status fields
	localparam int SC_STAMP_RST  = 0;
	localparam int SC_STAMP_EN   = 1;
	localparam int SC_FIRE_RST   = 2;
	localparam int SC_FIRE_EN    = 3;
	localparam int SC_FIRE_ACT   = 4;
	localparam int SC_STAMP_IEN  = 5;

	// Trigger control one fields
	localparam int TC_CHAIN_EN   = 31;
	localparam int TC_TAIL       = 30;
	localparam int TC_UP_LSB     = 26;
	localparam int TC_NOW        = 25;
	localparam int TC_NOTIFY     = 24;
	localparam int TC_EDGE       = 23;

	// Field widths and reset values
	localparam int NS_W          = 30;
	localparam logic [29:0] NS_RESET  = 30'h00000000;
	localparam logic [31:0] SEC_RESET = 32'h00000000;
	localparam logic [31:0] READ_ZERO = 32'h00000000;

	// Interrupt status layout: done bits low, error bits above
	localparam int IRQ_DONE_LSB  = 0;
	localparam int IRQ_ERR_LSB   = 4;

	typedef enum logic [1:0] {
		UNIT_IDLE,
		UNIT_CHECK,
		UNIT_WAIT
	} unit_state_t;

endpackage : fire_unit_pkg

// ==== fire_time_compare.sv ====
`timescale 1ns/1ns

// Compares system time against a target time in seconds and nanoseconds
module fire_time_compare
	import fire_unit_pkg::*;
(
	input  wire logic [31:0] now_sec_i,
	input  wire logic [29:0] now_ns_i,
	input  wire logic [31:0] tgt_sec_i,
	input  wire logic [29:0] tgt_ns_i,
	output logic             reached_o,
	output logic             passed_o
);

	// Seconds decide first, nanoseconds break a tie
	always_comb begin
		passed_o  = (now_sec_i > tgt_sec_i) ||
		            ((now_sec_i == tgt_sec_i) && (now_ns_i > tgt_ns_i));
		reached_o = passed_o || ((now_sec_i == tgt_sec_i) && (now_ns_i == tgt_ns_i));
	end

endmodule : fire_time_compare

// ==== fire_unit_top.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ns

// Function
// (R1) Stamp reset returns stamp unit to defaults
// (R2) Stamp reset acts on indexed stamp unit
// (R3) Nanosecond target is 30 bits, top zero
// (R4) Trigger registers steered by two-bit index
// (R5) Seconds target is full 32-bit, resets zero
// (R6) Chain enable puts unit in cascade
// (R7) Tail bit marks last unit of chain
// (R8) No tail means cascade repeats forever
// (R9) Unit soft reset stops endless cascade
// (R10) Upstream select picks unit starting this
// (R11) Trigger now fires at once when late
// (R12) Notify gates done, error and interrupt
// (R13) Edge bit selects launching clock edge
// (R14) Enable arms unit, clears on output
// (R15) Unit soft reset restores unit defaults
// (R16) Active reads one while running cleanly
// (R17) Target reached when time greater or equal
module fire_unit_top
	import fire_unit_pkg::*;
#(
	parameter int TRIGGERS = NUM_TRIG,
	parameter int STAMPS   = NUM_STAMP
) (
	input  wire logic              CLK_I,
	input  wire logic              SRST_I,
	input  wire logic [ADDR_W-1:0] ADDR_I,
	input  wire logic [31:0]       WDATA_I,
	input  wire logic              WR_I,
	input  wire logic              RD_I,
	output logic      [31:0]       RDATA_O,
	input  wire logic [31:0]       SYS_SEC_I,
	input  wire logic [29:0]       SYS_NS_I,
	output logic      [3:0]        TRIG_OUT_O,
	output logic      [1:0]        STAMP_RESET_O,
	output logic      [1:0]        STAMP_ENABLE_O,
	output logic      [1:0]        STAMP_IRQ_EN_O,
	output logic                   IRQ_O
);

	// The index fields are fixed at two bits and one bit wide
	if (TRIGGERS != 4 || STAMPS != 2) begin : g_size_check
		$error("fire_unit_top supports exactly four trigger and two stamp units");
	end

	// Write decode
	logic wr_index;
	logic wr_stamp;
	logic wr_ns;
	logic wr_sec;
	logic wr_ctl1;
	logic wr_irq_st;
	logic wr_irq_mk;

	assign wr_index  = WR_I && (ADDR_I == OFS_UNIT_INDEX);
	assign wr_stamp  = WR_I && (ADDR_I == OFS_STAMP_CTRL);
	assign wr_ns     = WR_I && (ADDR_I == OFS_TARGET_NS);
	assign wr_sec    = WR_I && (ADDR_I == OFS_TARGET_SEC);
	assign wr_ctl1   = WR_I && (ADDR_I == OFS_TRIG_CTRL1);
	assign wr_irq_st = WR_I && (ADDR_I == OFS_IRQ_STATUS);
	assign wr_irq_mk = WR_I && (ADDR_I == OFS_IRQ_MASK);

	// Unit index pointers
	logic [1:0] trig_idx_reg;
	logic       stamp_idx_reg;

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			trig_idx_reg  <= 2'h0;
			stamp_idx_reg <= 1'h0;
		end else if (wr_index) begin
			trig_idx_reg  <= WDATA_I[IDX_TRIG_LSB +: 2];
			stamp_idx_reg <= WDATA_I[IDX_STAMP_BIT];
		end
	end

	// Stamp input unit settings; a soft reset pulse returns them to default
	logic [1:0] stamp_en_reg;
	logic [1:0] stamp_ien_reg;
	logic [1:0] stamp_rst_reg;

	for (genvar s = 0; s < 2; s++) begin : g_stamp
		logic hit;
		assign hit = wr_stamp && (stamp_idx_reg == s[0]);

		always_ff @(posedge CLK_I) begin
			if (SRST_I) begin
				stamp_en_reg[s]  <= 1'h0;
				stamp_ien_reg[s] <= 1'h0;
				stamp_rst_reg[s] <= 1'h0;
			// (R2) Indexed stamp unit
			end else if (hit && WDATA_I[SC_STAMP_RST]) begin
				// (R1) Stamp defaults restored
				stamp_en_reg[s]  <= 1'h0;
				stamp_ien_reg[s] <= 1'h0;
				stamp_rst_reg[s] <= 1'h1;
			end else begin
				stamp_rst_reg[s] <= 1'h0;
				if (hit) begin
					stamp_en_reg[s]  <= WDATA_I[SC_STAMP_EN];
					stamp_ien_reg[s] <= WDATA_I[SC_STAMP_IEN];
				end
			end
		end
	end

	assign STAMP_RESET_O  = stamp_rst_reg;
	assign STAMP_ENABLE_O = stamp_en_reg;
	assign STAMP_IRQ_EN_O = stamp_ien_reg;

	// Per-unit views gathered for readback and chaining
	logic [3:0][29:0] unit_ns;
	logic [3:0][31:0] unit_sec;
	logic [3:0][31:0] unit_ctl;
	logic [3:0]       unit_en;
	logic [3:0]       unit_act;
	logic [3:0]       unit_tail;
	logic [3:0]       fire_ev;
	logic [3:0]       err_ev;
	logic [3:0]       notify;
	logic [3:0]       out_pos_reg;
	logic [3:0]       out_neg_reg;

	for (genvar i = 0; i < 4; i++) begin : g_unit
		logic [29:0] ns_reg;
		logic [31:0] sec_reg;
		logic        chain_reg;
		logic        tail_reg;
		logic [1:0]  up_reg;
		logic        now_reg;
		logic        notify_reg;
		logic        edge_reg;
		logic        en_reg;
		unit_state_t state_reg;
		unit_state_t state_next;
		logic        sel;
		logic        soft_rst;
		logic        arm_sw;
		logic        arm_up;
		logic        reached;
		logic        passed;
		logic        late_err;

		// (R4) Index steers access
		assign sel      = (trig_idx_reg == i[1:0]);
		// (R9) Soft reset halts
		assign soft_rst = wr_stamp && sel && WDATA_I[SC_FIRE_RST];
		// (R14) Enable arms unit
		assign arm_sw   = wr_stamp && sel && WDATA_I[SC_FIRE_EN];
		// (R10) Upstream done select
		assign arm_up   = chain_reg && fire_ev[up_reg] && !unit_tail[up_reg];

		// (R17) Greater or equal
		fire_time_compare u_cmp (
			.now_sec_i (SYS_SEC_I),
			.now_ns_i  (SYS_NS_I),
			.tgt_sec_i (sec_reg),
			.tgt_ns_i  (ns_reg),
			.reached_o (reached),
			.passed_o  (passed)
		);

		// (R11) Late without trigger now
		assign late_err = (state_reg == UNIT_CHECK) && passed && !now_reg;
		assign fire_ev[i] = reached && !late_err &&
		                    ((state_reg == UNIT_CHECK) || (state_reg == UNIT_WAIT));
		assign err_ev[i]  = late_err;

		// Target time and control fields
		always_ff @(posedge CLK_I) begin
			if (SRST_I || soft_rst) begin
				// (R15) Unit defaults
				ns_reg     <= NS_RESET;
				sec_reg    <= SEC_RESET;
				chain_reg  <= 1'h0;
				tail_reg   <= 1'h0;
				up_reg     <= 2'h0;
				now_reg    <= 1'h0;
				notify_reg <= 1'h0;
				edge_reg   <= 1'h0;
			end else begin
				// (R3) Thirty-bit field
				if (wr_ns && sel) begin
					ns_reg <= WDATA_I[NS_W-1:0];
				end
				// (R5) Full seconds
				if (wr_sec && sel) begin
					sec_reg <= WDATA_I;
				end
				if (wr_ctl1 && sel) begin
					// (R6) Cascade mode
					chain_reg  <= WDATA_I[TC_CHAIN_EN];
					// (R7) Tail marker
					tail_reg   <= WDATA_I[TC_TAIL];
					up_reg     <= WDATA_I[TC_UP_LSB +: 2];
					now_reg    <= WDATA_I[TC_NOW];
					notify_reg <= WDATA_I[TC_NOTIFY];
					edge_reg   <= WDATA_I[TC_EDGE];
				end
			end
		end

		// Enable bit, cleared by hardware once the unit finishes
		always_ff @(posedge CLK_I) begin
			if (SRST_I || soft_rst) begin
				en_reg <= 1'h0;
			end else if (arm_sw) begin
				en_reg <= 1'h1;
			// (R14) Self clearing
			end else if (fire_ev[i] || err_ev[i]) begin
				en_reg <= 1'h0;
			end else if (wr_stamp && sel) begin
				en_reg <= 1'h0;
			end
		end

		// Arming sequence: check once for lateness, then wait for target
		always_comb begin
			state_next = state_reg;
			unique case (state_reg)
				UNIT_IDLE: begin
					if (arm_sw || arm_up) begin
						state_next = UNIT_CHECK;
					end
				end
				UNIT_CHECK: begin
					if (late_err || fire_ev[i]) begin
						state_next = UNIT_IDLE;
					end else begin
						state_next = UNIT_WAIT;
					end
				end
				UNIT_WAIT: begin
					if (fire_ev[i]) begin
						state_next = UNIT_IDLE;
					end
				end
				default: state_next = UNIT_IDLE;
			endcase
		end

		always_ff @(posedge CLK_I) begin
			if (SRST_I || soft_rst) begin
				state_reg <= UNIT_IDLE;
			end else if (wr_stamp && sel && !WDATA_I[SC_FIRE_EN]) begin
				state_reg <= UNIT_IDLE; // Software disable
			end else begin
				state_reg <= state_next;
			end
		end

		// Output pulse launched on the rising edge
		always_ff @(posedge CLK_I) begin
			if (SRST_I || soft_rst) begin
				out_pos_reg[i] <= 1'h0;
			end else begin
				out_pos_reg[i] <= fire_ev[i];
			end
		end

		// (R13) Falling edge copy
		always_ff @(negedge CLK_I) begin
			if (SRST_I) begin
				out_neg_reg[i] <= 1'h0;
			end else begin
				out_neg_reg[i] <= out_pos_reg[i];
			end
		end

		// (R13) Edge select
		assign TRIG_OUT_O[i] = edge_reg ? out_neg_reg[i] : out_pos_reg[i];

		// Views for readback and neighbouring units
		assign unit_ns[i]   = ns_reg;
		assign unit_sec[i]  = sec_reg;
		assign unit_ctl[i]  = {chain_reg, tail_reg, 2'h0, up_reg, now_reg, notify_reg,
		                       edge_reg, 23'h000000};
		assign unit_en[i]   = en_reg;
		// (R16) Active while running
		assign unit_act[i]  = (state_reg != UNIT_IDLE);
		// (R8) Tail absence loops
		assign unit_tail[i] = tail_reg;
		assign notify[i]    = notify_reg;
	end

	// Sticky done and error flags; a new event wins over a clearing write
	logic [7:0] irq_st_reg;
	logic [7:0] irq_mk_reg;
	logic [7:0] irq_set;
	logic [7:0] irq_clr;

	// (R12) Notify gates status
	assign irq_set = {err_ev & notify, fire_ev & notify};
	assign irq_clr = wr_irq_st ? WDATA_I[7:0] : 8'h00;

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			irq_st_reg <= 8'h00;
		end else begin
			irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			irq_mk_reg <= 8'h00;
		end else if (wr_irq_mk) begin
			irq_mk_reg <= WDATA_I[7:0];
		end
	end

	// (R12) Interrupt when unmasked
	assign IRQ_O = |(irq_st_reg & irq_mk_reg);

	// Read data registered, valid the cycle after the read strobe
	logic [31:0] rdata_next;
	logic [31:0] rdata_reg;

	always_comb begin
		rdata_next = READ_ZERO;
		unique case (ADDR_I)
			OFS_UNIT_INDEX: begin
				rdata_next[IDX_TRIG_LSB +: 2] = trig_idx_reg;
				rdata_next[IDX_STAMP_BIT]     = stamp_idx_reg;
			end
			OFS_STAMP_CTRL: begin
				rdata_next[SC_STAMP_EN]  = stamp_en_reg[stamp_idx_reg];
				rdata_next[SC_STAMP_IEN] = stamp_ien_reg[stamp_idx_reg];
				rdata_next[SC_FIRE_EN]   = unit_en[trig_idx_reg];
				rdata_next[SC_FIRE_ACT]  = unit_act[trig_idx_reg];
			end
			// (R3) Reserved read zero
			OFS_TARGET_NS:  rdata_next = {2'h0, unit_ns[trig_idx_reg]};
			OFS_TARGET_SEC: rdata_next = unit_sec[trig_idx_reg];
			OFS_TRIG_CTRL1: rdata_next = unit_ctl[trig_idx_reg];
			OFS_IRQ_STATUS: rdata_next = {24'h000000, irq_st_reg};
			OFS_IRQ_MASK:   rdata_next = {24'h000000, irq_mk_reg};
			default:        rdata_next = READ_ZERO;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rdata_reg <= READ_ZERO;
		end else if (RD_I) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= READ_ZERO;
		end
	end

	assign RDATA_O = rdata_reg;

endmodule : fire_unit_top

// ==== fire_unit_monitor.sv ====
`timescale 1ns/1ns

// Port-level checks of the trigger output block
module fire_unit_monitor
	import fire_unit_pkg::*;
(
	input wire logic              CLK_I,
	input wire logic              SRST_I,
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic [31:0]       WDATA_I,
	input wire logic              WR_I,
	input wire logic              RD_I,
	input wire logic [31:0]       RDATA_O,
	input wire logic [3:0]        TRIG_OUT_O,
	input wire logic [1:0]        STAMP_RESET_O,
	input wire logic [1:0]        STAMP_ENABLE_O,
	input wire logic [1:0]        STAMP_IRQ_EN_O,
	input wire logic              IRQ_O
);
	logic       s_idx_reg;
	logic [1:0] t_idx_reg;
	logic       ctl_wr;
	logic       stamp_req;
	logic [1:0] rst_unit_reg;

	// Decoded control writes
	assign ctl_wr    = WR_I && ADDR_I == OFS_STAMP_CTRL;
	assign stamp_req = ctl_wr && WDATA_I[SC_STAMP_RST];

	// Shadow of the index pointers
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			s_idx_reg <= 1'b0;
			t_idx_reg <= 2'h0;
		end else if (WR_I && ADDR_I == OFS_UNIT_INDEX) begin
			s_idx_reg <= WDATA_I[IDX_STAMP_BIT];
			t_idx_reg <= WDATA_I[1:0];
		end
	end

	// Trigger unit named by the latest unit soft reset
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rst_unit_reg <= 2'h0;
		end else if (ctl_wr && WDATA_I[SC_FIRE_RST]) begin
			rst_unit_reg <= t_idx_reg;
		end
	end

	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	sequence s_unit_rst;
		ctl_wr && WDATA_I[SC_FIRE_RST];
	endsequence
	sequence s_quiet;
		##2 (!TRIG_OUT_O[rst_unit_reg]) [*4];
	endsequence

	property p_ns_rsv;
		RD_I && ADDR_I == OFS_TARGET_NS |=> RDATA_O[31:30] == 2'b00;
	endproperty
	property p_ctl_selfclr;
		RD_I && ADDR_I == OFS_STAMP_CTRL |=> !RDATA_O[SC_FIRE_RST] && !RDATA_O[SC_STAMP_RST];
	endproperty
	property p_up_rsv;
		RD_I && ADDR_I == OFS_TRIG_CTRL1 |=> RDATA_O[29:28] == 2'b00;
	endproperty
	property p_stamp_pulse;
		stamp_req |=> STAMP_RESET_O == (2'b01 << s_idx_reg);
	endproperty
	property p_stamp_cause;
		STAMP_RESET_O != 2'b00 |-> $past(stamp_req);
	endproperty
	property p_stamp_dflt;
		stamp_req && !WDATA_I[SC_STAMP_EN] && !WDATA_I[SC_STAMP_IEN]
			|=> !STAMP_ENABLE_O[s_idx_reg] && !STAMP_IRQ_EN_O[s_idx_reg];
	endproperty
	property p_rst_quiet;
		s_unit_rst |=> s_quiet;
	endproperty
	property p_pulse_one;
		TRIG_OUT_O != 4'h0 |=> (TRIG_OUT_O & $past(TRIG_OUT_O)) == 4'h0;
	endproperty
	property p_mask_off;
		WR_I && ADDR_I == OFS_IRQ_MASK && WDATA_I == 32'h0 |=> !IRQ_O;
	endproperty

	a_ns_rsv: assert property (p_ns_rsv) else $error("ns reserved bits set");
	a_ctl_selfclr: assert property (p_ctl_selfclr) else $error("reset bit reads one");
	a_up_rsv: assert property (p_up_rsv) else $error("ctrl1 reserved set");
	a_stamp_pulse: assert property (p_stamp_pulse) else $error("stamp reset wrong");
	a_stamp_cause: assert property (p_stamp_cause) else $error("stamp reset stray");
	a_stamp_dflt: assert property (p_stamp_dflt) else $error("stamp not default");
	a_rst_quiet: assert property (p_rst_quiet) else $error("unit fires after reset");
	a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
	a_mask_off: assert property (p_mask_off) else $error("masked irq high");
endmodule : fire_unit_monitor

bind fire_unit_top fire_unit_monitor i_mon (.CLK_I, .SRST_I, .ADDR_I, .WDATA_I, .WR_I,
	.RD_I, .RDATA_O, .TRIG_OUT_O, .STAMP_RESET_O, .STAMP_ENABLE_O, .STAMP_IRQ_EN_O, .IRQ_O);

// ==== tb.sv ====
`timescale 1ns/1ns

// Self-checking bench for the trigger output units
module tb
	import fire_unit_pkg::*;
;
	logic        CLK_I = 0, SRST_I = 1, WR_I = 0, RD_I = 0, IRQ_O;
	logic [11:0] ADDR_I = 12'h000;
	logic [31:0] WDATA_I = 32'h0, SYS_SEC_I = 32'h0, RDATA_O, seed = 32'h338F;
	logic [29:0] SYS_NS_I = 30'h0;
	logic [3:0]  TRIG_OUT_O;
	logic [1:0]  STAMP_RESET_O, STAMP_ENABLE_O, STAMP_IRQ_EN_O;
	logic [31:0] m_ns[4], m_sec[4];
	logic [31:0] ctl_tab[3] = '{32'h0100_0000, 32'h0380_0000, 32'h0200_0000};
	int          n_fail = 0, total_checks = 0, cnt[4];

	always #50 CLK_I = ~CLK_I;

	fire_unit_top i_dut (.CLK_I, .SRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
		.SYS_SEC_I, .SYS_NS_I, .TRIG_OUT_O, .STAMP_RESET_O, .STAMP_ENABLE_O,
		.STAMP_IRQ_EN_O, .IRQ_O);

	// Pulse counters per unit, sampled mid-cycle where rising-edge pulses are settled
	always @(negedge CLK_I) foreach (cnt[k]) cnt[k] += TRIG_OUT_O[k];

	function logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// Model: pulse of unit u after arming, none if late without trigger now
	function automatic logic [3:0] model_out(input logic [31:0] ctl, input int u,
		input bit late);
		if (late && !ctl[TC_NOW]) return 4'h0;
		return 4'h1 << u;
	endfunction : model_out

	// Model: status bit raised by that arming, only when notify is set
	function automatic logic [31:0] model_status(input logic [31:0] ctl, input int u,
		input bit late);
		if (!ctl[TC_NOTIFY]) return 32'h0;
		if (late && !ctl[TC_NOW]) return 32'h1 << (IRQ_ERR_LSB + u);
		return 32'h1 << (IRQ_DONE_LSB + u);
	endfunction : model_status

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask : cyc

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1 chk(RDATA_O, exp);
	endtask : rd

	// Waits a bounded span for a pulse, then compares it
	task fire_chk(input logic [3:0] exp);
		int n;
		n = 0;
		#1;
		while (TRIG_OUT_O === 4'h0 && n < 6) begin
			cyc(1);
			n++;
		end
		chk(TRIG_OUT_O, exp);
	endtask : fire_chk

	task give_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict

	initial begin
		#2000000;
		n_fail++;
		$display("[ERR] t=%0t watchdog expired", $time);
		give_verdict();
	end

	initial begin
		repeat (2) @(posedge CLK_I);
		SRST_I <= 1'b0;
		rd(OFS_TARGET_NS, 32'h0);
		rd(OFS_TARGET_SEC, 32'h0);
		rd(OFS_TRIG_CTRL1, 32'h0);
		rd(12'h000, 32'h0);
		for (int u = 0; u < 4; u++) begin
			wr(OFS_UNIT_INDEX, u);
			seed = lfsr(seed);
			m_ns[u] = seed & 32'h3FFF_FFFF;
			wr(OFS_TARGET_NS, seed);
			seed = lfsr(seed);
			m_sec[u] = seed;
			wr(OFS_TARGET_SEC, seed);
		end
		for (int u = 0; u < 4; u++) begin
			wr(OFS_UNIT_INDEX, u);
			rd(OFS_TARGET_NS, m_ns[u]);
			rd(OFS_TARGET_SEC, m_sec[u]);
		end
		$display("storage test done");
		@(posedge CLK_I);
		SYS_SEC_I <= 32'h5;
		SYS_NS_I <= 30'h64;
		wr(OFS_UNIT_INDEX, 1);
		wr(OFS_TARGET_NS, 32'h64);
		wr(OFS_TARGET_SEC, 32'h5);
		wr(OFS_TRIG_CTRL1, 32'h0100_0000);
		wr(OFS_IRQ_MASK, 32'h2);
		wr(OFS_STAMP_CTRL, 32'h8);
		fire_chk(4'h2);
		rd(OFS_IRQ_STATUS, 32'h2);
		rd(OFS_STAMP_CTRL, 32'h0);
		chk(IRQ_O, 1'b1);
		wr(OFS_IRQ_STATUS, 32'h2);
		chk(IRQ_O, 1'b0);
		wr(OFS_UNIT_INDEX, 2);
		wr(OFS_TARGET_NS, 32'h0);
		wr(OFS_TARGET_SEC, 32'h7);
		wr(OFS_TRIG_CTRL1, 32'h0);
		wr(OFS_STAMP_CTRL, 32'h8);
		rd(OFS_STAMP_CTRL, 32'h18);
		chk(TRIG_OUT_O, 4'h0);
		@(posedge CLK_I);
		SYS_SEC_I <= 32'h7;
		fire_chk(4'h4);
		$display("fire test done");
		wr(OFS_UNIT_INDEX, 3);
		wr(OFS_TARGET_SEC, 32'h1);
		wr(OFS_IRQ_MASK, 32'hFF);
		for (int c = 0; c < 3; c++) begin
			wr(OFS_TRIG_CTRL1, ctl_tab[c]);
			wr(OFS_STAMP_CTRL, 32'h8);
			cyc(1);
			chk(TRIG_OUT_O, ctl_tab[c][TC_EDGE] ? 4'h0 : model_out(ctl_tab[c], 3, 1));
			fire_chk(model_out(ctl_tab[c], 3, 1));
			rd(OFS_IRQ_STATUS, model_status(ctl_tab[c], 3, 1));
			chk(IRQ_O, model_status(ctl_tab[c], 3, 1) != 0);
			wr(OFS_IRQ_STATUS, 32'hFF);
		end
		$display("late test done");
		for (int s = 0; s < 2; s++) begin
			wr(OFS_UNIT_INDEX, s << 8);
			wr(OFS_STAMP_CTRL, 32'h22);
			chk(STAMP_ENABLE_O, 2'b01 << s);
			chk(STAMP_IRQ_EN_O, 2'b01 << s);
			wr(OFS_STAMP_CTRL, 32'h1);
			chk(STAMP_RESET_O, 2'b01 << s);
			chk(STAMP_IRQ_EN_O, 2'h0);
		end
		$display("stamp test done");
		wr(OFS_IRQ_MASK, 32'h0);
		for (int u = 0; u < 2; u++) begin
			wr(OFS_UNIT_INDEX, u);
			wr(OFS_TARGET_SEC, 32'h0);
			wr(OFS_TRIG_CTRL1, 32'h8200_0000 | ((1 - u) << TC_UP_LSB));
		end
		wr(OFS_UNIT_INDEX, 0);
		cnt = '{0, 0, 0, 0};
		wr(OFS_STAMP_CTRL, 32'h8);
		cyc(20);
		chk(cnt[0] > 2 && cnt[1] > 2, 1);
		wr(OFS_STAMP_CTRL, 32'h4);
		wr(OFS_UNIT_INDEX, 1);
		wr(OFS_STAMP_CTRL, 32'h4);
		cnt = '{0, 0, 0, 0};
		cyc(10);
		chk(cnt[0] + cnt[1], 0);
		rd(OFS_TRIG_CTRL1, 32'h0);
		wr(OFS_TRIG_CTRL1, 32'hC200_0000);
		wr(OFS_UNIT_INDEX, 0);
		wr(OFS_TRIG_CTRL1, 32'h8600_0000);
		cnt = '{0, 0, 0, 0};
		wr(OFS_STAMP_CTRL, 32'h8);
		cyc(12);
		chk(cnt[0], 1);
		chk(cnt[1], 1);
		$display("chain test done");
		give_verdict();
	end
endmodule : tb
